// *** verilog/adcc_consts.svh ***
// constants for the converter control block
`ifndef ADCC_CONSTS_SVH
`define ADCC_CONSTS_SVH
// register indices, and byte addresses at four bytes per index
`define ADCC_IDX_CTRL 8'h08
`define ADCC_IDX_RES 8'h09
`define ADCC_IDX_INTC 8'h0b
`define ADCC_IDX_PCFG 8'h88
`define ADCC_AW 10
`define ADCC_ADDR_CTRL 10'h020
`define ADCC_ADDR_RES 10'h024
`define ADCC_ADDR_INTC 10'h02c
`define ADCC_ADDR_PCFG 10'h220
`define ADCC_RST_CTRL 8'h00
`define ADCC_RST_PCFG 8'h00
`define ADCC_RST_INTC 8'h00
// conv_control_status fields
`define ADCC_B_CLKSEL_HI 7
`define ADCC_B_CLKSEL_LO 6
`define ADCC_B_GP 5
`define ADCC_B_CHAN_HI 4
`define ADCC_B_CHAN_LO 3
`define ADCC_B_GO 2
`define ADCC_B_DONE 1
`define ADCC_B_PWR 0
// interrupt_control enable bit position (arbitrary placement)
`define ADCC_B_IRQ_EN 6
// oscillator periods per conversion clock, and cycle counts
`define ADCC_DIV_2 8'h02
`define ADCC_DIV_8 8'h08
`define ADCC_DIV_32 8'h20
`define ADCC_CONV_TADS 4'ha
`define ADCC_HOLDOFF_TADS 4'h2
`define ADCC_RES_BITS 4'h8
`define ADCC_SETTLE_TADS 4'h2
`endif

// *** verilog/adcc_pkg.sv ***
// types for the converter control block
`default_nettype none
package adcc_pkg;
    typedef enum logic [3:0] {
        ADCC_OFF = 4'h1,
        ADCC_TRACK = 4'h2,
        ADCC_CONVERT = 4'h4,
        ADCC_HOLDOFF = 4'h8
    } adcc_state_e;
endpackage : adcc_pkg
`default_nettype wire

// *** verilog/adcc_tick_gen.sv ***
// conversion clock tick generator from main oscillator or rc oscillator
`timescale 1ns/1ps
`default_nettype none
`include "adcc_consts.svh"
module adcc_tick_gen (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic run,
    input wire logic [1:0] clkSel,
    input wire logic oscTick,
    input wire logic rcClkSync,
    output logic tadTick
);
    logic [7:0] cnt_ff;
    logic [7:0] divLen;
    logic rcPrev_ff;

    // period chooser; code 11 selects the rc oscillator edge instead
    always_comb begin
        case (clkSel)
            2'b00: divLen = `ADCC_DIV_2;
            2'b01: divLen = `ADCC_DIV_8;
            default: divLen = `ADCC_DIV_32;
        endcase
    end

    // oscillator period counter, held clear while idle so phase is fresh
    always_ff @(posedge sys_clk) begin
        if (!rst_n || !run) begin
            cnt_ff <= 8'h00;
        end else if (clkSel != 2'b11 && oscTick) begin
            if (cnt_ff == divLen - 8'h01) begin
                cnt_ff <= 8'h00;
            end else begin
                cnt_ff <= cnt_ff + 8'h01;
            end
        end
    end

    // rc edge detector works on the already synchronised level
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            rcPrev_ff <= 1'b0;
        end else begin
            rcPrev_ff <= rcClkSync;
        end
    end

    assign tadTick = run && ((clkSel == 2'b11) ? (rcClkSync && !rcPrev_ff)
                             : (oscTick && cnt_ff == divLen - 8'h01));
endmodule : adcc_tick_gen
`default_nettype wire

// *** verilog/adcc_conv_ctrl.sv ***
// converter control: registers, sequencer, track and hold control
//
// The Avalon-MM slave port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "adcc_consts.svh"
// Notes on behaviour
// RULE1 - one of four channels routed to the shared track-and-hold
// RULE2 - writing one to go starts a conversion
// RULE3 - finishing clears go and sets done flag
// RULE4 - eight-bit result lands in result register at 09h
// RULE5 - two-bit select gives 2, 8, 32 oscillator periods or rc
// RULE6 - one bit per conversion clock, ten conversion clocks total
// RULE7 - software keeps conversion clock period at least two microseconds
// RULE8 - power-on bit zero switches off standing-current circuits
// RULE9 - powered with valid channel, input tracks continuously
// RULE10 - conversion start ends tracking, converts held voltage
// RULE11 - two conversion clocks after completion before tracking resumes
// RULE12 - software selects channel and allows tracking time first
// RULE13 - halt during rc conversion completes, sets done, may wake
// RULE14 - halt during oscillator conversion aborts and shuts converter off
// RULE15 - after abort software restarts with fresh tracking
// RULE16 - reference from reference pin or supply by pin config
// RULE17 - control register resets to zero with documented field order
// RULE18 - first code transition at one lsb, full scale over 256
// RULE19 - software sets analog pins as inputs in direction register
// RULE20 - msb first, result register updated only at completion
module adcc_conv_ctrl (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [9:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic oscTick,
    input wire logic rcClkPin,
    input wire logic haltActive,
    input wire logic compHigh,
    output logic [1:0] channelSel,
    output logic trackEnable,
    output logic converterPowered,
    output logic useRefPin,
    output logic [7:0] dacCode,
    output logic wakeRequest
);
    logic [7:0] ctrl_ff;
    logic [7:0] pcfg_ff;
    logic [7:0] intc_ff;
    logic [7:0] result_ff;
    logic [7:0] sar_ff;
    logic [3:0] tadCnt_ff;
    logic [7:0] rdata_ff;
    logic ack_ff;
    logic wake_ff;
    logic rcMeta_ff;
    logic rcSync_ff;
    logic haltMeta_ff;
    logic haltSync_ff;
    logic compMeta_ff;
    logic compSync_ff;
    adcc_pkg::adcc_state_e state_ff;
    adcc_pkg::adcc_state_e nxt_state;
    logic tadTick;
    logic wrCtrl;
    logic convDone;
    logic convAbort;
    logic goWrite;
    logic accessTaken;
    logic [1:0] wrChanSel;

    // picks the byte lane 0 write, used by the control, pin config and interrupt registers
    function automatic logic laneWrite(input logic [9:0] adr, input logic [9:0] target,
                                       input logic wr, input logic be0);
        laneWrite = wr && be0 && adr == target;
    endfunction : laneWrite

    // two-flop synchronisers for pin-side inputs
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            rcMeta_ff <= 1'b0;
            rcSync_ff <= 1'b0;
            haltMeta_ff <= 1'b0;
            haltSync_ff <= 1'b0;
            compMeta_ff <= 1'b0;
            compSync_ff <= 1'b0;
        end else begin
            rcMeta_ff <= rcClkPin;
            rcSync_ff <= rcMeta_ff;
            haltMeta_ff <= haltActive;
            haltSync_ff <= haltMeta_ff;
            compMeta_ff <= compHigh;
            compSync_ff <= compMeta_ff;
        end
    end

    // RULE5 conversion clock select
    adcc_tick_gen u_tick (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .run(state_ff != adcc_pkg::ADCC_OFF),
        .clkSel(ctrl_ff[`ADCC_B_CLKSEL_HI:`ADCC_B_CLKSEL_LO]),
        .oscTick(oscTick),
        .rcClkSync(rcSync_ff),
        .tadTick(tadTick)
    );

    // one wait state: answer on the second cycle of every request
    assign accessTaken = (avs_read || avs_write) && ack_ff;
    assign avs_waitrequest = (avs_read || avs_write) && !ack_ff;
    assign wrCtrl = accessTaken
                    && laneWrite(avs_address, `ADCC_ADDR_CTRL, avs_write, avs_byteenable[0]);
    assign goWrite = wrCtrl && avs_writedata[`ADCC_B_GO];
    assign wrChanSel = avs_writedata[`ADCC_B_CHAN_HI:`ADCC_B_CHAN_LO];
    assign convDone = state_ff == adcc_pkg::ADCC_CONVERT && tadTick
                      && tadCnt_ff == `ADCC_CONV_TADS - 4'h1;
    // RULE14 halt with oscillator clock aborts
    assign convAbort = state_ff == adcc_pkg::ADCC_CONVERT && haltSync_ff
                       && ctrl_ff[`ADCC_B_CLKSEL_HI:`ADCC_B_CLKSEL_LO] != 2'b11;

    // handshake flop, drops after each answered cycle
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= (avs_read || avs_write) && !ack_ff;
        end
    end

    // read mux sampled into a flop so readdata is stable at the answer edge
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            rdata_ff <= 8'h00;
        end else if (avs_read && !ack_ff) begin
            case (avs_address)
                `ADCC_ADDR_CTRL: rdata_ff <= ctrl_ff;
                `ADCC_ADDR_RES: rdata_ff <= result_ff;
                `ADCC_ADDR_INTC: rdata_ff <= intc_ff;
                `ADCC_ADDR_PCFG: rdata_ff <= pcfg_ff;
                default: rdata_ff <= 8'h00;
            endcase
        end
    end
    assign avs_readdata = {24'h000000, rdata_ff};

    // RULE17 control register, reset to zero
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            ctrl_ff <= `ADCC_RST_CTRL;
        end else begin
            if (wrCtrl) begin
                ctrl_ff <= avs_writedata[7:0];
            end
            // RULE3 go clears, done sets; hardware set beats software clear
            if (convDone) begin
                ctrl_ff[`ADCC_B_GO] <= 1'b0;
                ctrl_ff[`ADCC_B_DONE] <= 1'b1;
            end
            // RULE14 abort shuts converter and drops go
            if (convAbort) begin
                ctrl_ff[`ADCC_B_GO] <= 1'b0;
                ctrl_ff[`ADCC_B_PWR] <= 1'b0;
            end
            // go written while powered off or mid-sequence does not stick
            if (goWrite && (!avs_writedata[`ADCC_B_PWR] || state_ff != adcc_pkg::ADCC_TRACK)) begin
                ctrl_ff[`ADCC_B_GO] <= 1'b0;
            end
        end
    end

    // RULE16 pin configuration and the interrupt enable register
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            pcfg_ff <= `ADCC_RST_PCFG;
            intc_ff <= `ADCC_RST_INTC;
        end else begin
            if (avs_write && ack_ff
                && laneWrite(avs_address, `ADCC_ADDR_PCFG, avs_write, avs_byteenable[0])) begin
                pcfg_ff <= {6'h00, avs_writedata[1:0]};
            end
            if (avs_write && ack_ff
                && laneWrite(avs_address, `ADCC_ADDR_INTC, avs_write, avs_byteenable[0])) begin
                intc_ff <= avs_writedata[7:0];
            end
        end
    end

    // sequencer next state
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            // RULE8 off until power bit set
            adcc_pkg::ADCC_OFF: begin
                if (ctrl_ff[`ADCC_B_PWR]) begin
                    nxt_state = adcc_pkg::ADCC_TRACK;
                end
            end
            // RULE2 go starts conversion
            adcc_pkg::ADCC_TRACK: begin
                if (!ctrl_ff[`ADCC_B_PWR]) begin
                    nxt_state = adcc_pkg::ADCC_OFF;
                end else if (ctrl_ff[`ADCC_B_GO]) begin
                    nxt_state = adcc_pkg::ADCC_CONVERT;
                end
            end
            adcc_pkg::ADCC_CONVERT: begin
                if (convAbort || !ctrl_ff[`ADCC_B_PWR]) begin
                    nxt_state = adcc_pkg::ADCC_OFF;
                end else if (convDone) begin
                    nxt_state = adcc_pkg::ADCC_HOLDOFF;
                end
            end
            // RULE11 two conversion clocks before tracking
            adcc_pkg::ADCC_HOLDOFF: begin
                if (!ctrl_ff[`ADCC_B_PWR]) begin
                    nxt_state = adcc_pkg::ADCC_OFF;
                end else if (tadTick && tadCnt_ff == `ADCC_HOLDOFF_TADS - 4'h1) begin
                    nxt_state = adcc_pkg::ADCC_TRACK;
                end
            end
            default: nxt_state = adcc_pkg::ADCC_OFF;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            state_ff <= adcc_pkg::ADCC_OFF;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // RULE6 conversion clock counter, restarts on each state change
    always_ff @(posedge sys_clk) begin
        if (!rst_n || nxt_state != state_ff) begin
            tadCnt_ff <= 4'h0;
        end else if (tadTick) begin
            tadCnt_ff <= tadCnt_ff + 4'h1;
        end
    end

    // RULE20 msb first trial bits; first two periods settle the held sample
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            sar_ff <= 8'h00;
        end else if (state_ff == adcc_pkg::ADCC_TRACK) begin
            sar_ff <= 8'h80;
        end else if (state_ff == adcc_pkg::ADCC_CONVERT && tadTick
                     && tadCnt_ff >= `ADCC_CONV_TADS - `ADCC_RES_BITS) begin
            // RULE18 comparator judges input against the trial code
            sar_ff <= sar_ff & ~(compSync_ff ? 8'h00 : (8'h80 >> (tadCnt_ff - `ADCC_SETTLE_TADS)))
                      | ((tadCnt_ff == `ADCC_CONV_TADS - 4'h1) ? 8'h00
                         : (8'h40 >> (tadCnt_ff - `ADCC_SETTLE_TADS)));
        end
    end

    // RULE4 result written only at completion
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            result_ff <= 8'h00;
        end else if (convDone) begin
            result_ff <= compSync_ff ? sar_ff : (sar_ff & 8'hfe);
        end
    end

    // RULE13 done with enable raises a wake request
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            wake_ff <= 1'b0;
        end else begin
            wake_ff <= ctrl_ff[`ADCC_B_DONE] && intc_ff[`ADCC_B_IRQ_EN];
        end
    end

    // RULE1 channel routing and RULE9 continuous tracking
    assign channelSel = ctrl_ff[`ADCC_B_CHAN_HI:`ADCC_B_CHAN_LO];
    // RULE10 hold during conversion
    assign trackEnable = state_ff == adcc_pkg::ADCC_TRACK;
    assign converterPowered = state_ff != adcc_pkg::ADCC_OFF;
    assign useRefPin = pcfg_ff[0];
    assign dacCode = sar_ff;
    assign wakeRequest = wake_ff;

    // RULE3 done follows the last conversion clock
    property p_done_sets;
        @(posedge sys_clk) disable iff (!rst_n)
        convDone && !convAbort |=> ctrl_ff[`ADCC_B_DONE] && !ctrl_ff[`ADCC_B_GO];
    endproperty
    a_done_sets: assert property (p_done_sets) else $error("done not set"); // RULE3

    // RULE11 holdoff lasts beyond its first cycle
    property p_holdoff;
        @(posedge sys_clk) disable iff (!rst_n)
        $rose(state_ff == adcc_pkg::ADCC_HOLDOFF) |=> !trackEnable;
    endproperty
    a_holdoff: assert property (p_holdoff) else $error("tracked too soon"); // RULE11

    // RULE10 conversion entered only from tracking, which it ends
    property p_hold;
        @(posedge sys_clk) disable iff (!rst_n)
        $rose(state_ff == adcc_pkg::ADCC_CONVERT) |-> $past(trackEnable) && !trackEnable;
    endproperty
    a_hold: assert property (p_hold) else $error("tracking during convert"); // RULE10

    // RULE14 abort powers down
    property p_abort;
        @(posedge sys_clk) disable iff (!rst_n)
        convAbort |=> !converterPowered && !ctrl_ff[`ADCC_B_PWR];
    endproperty
    a_abort: assert property (p_abort) else $error("abort left converter on"); // RULE14

    // RULE8 power off means converter off next cycle
    property p_off;
        @(posedge sys_clk) disable iff (!rst_n)
        !ctrl_ff[`ADCC_B_PWR] ##1 !ctrl_ff[`ADCC_B_PWR] |-> !converterPowered;
    endproperty
    a_off: assert property (p_off) else $error("powered while off"); // RULE8

    // RULE20 result only moves at completion
    property p_result;
        @(posedge sys_clk) disable iff (!rst_n)
        !convDone |=> $stable(result_ff);
    endproperty
    a_result: assert property (p_result) else $error("result moved early"); // RULE20

    // RULE2 go in tracking starts conversion
    property p_start;
        @(posedge sys_clk) disable iff (!rst_n)
        state_ff == adcc_pkg::ADCC_TRACK && ctrl_ff[`ADCC_B_GO] && ctrl_ff[`ADCC_B_PWR]
        |=> state_ff == adcc_pkg::ADCC_CONVERT;
    endproperty
    a_start: assert property (p_start) else $error("go ignored"); // RULE2

    // RULE13 wake follows enabled done
    property p_wake;
        @(posedge sys_clk) disable iff (!rst_n)
        ctrl_ff[`ADCC_B_DONE] && intc_ff[`ADCC_B_IRQ_EN] |=> wakeRequest;
    endproperty
    a_wake: assert property (p_wake) else $error("no wake"); // RULE13

    // RULE1 channel output follows register
    property p_chan;
        @(posedge sys_clk) disable iff (!rst_n)
        wrCtrl |=> channelSel == $past(wrChanSel);
    endproperty
    a_chan: assert property (p_chan) else $error("channel not routed"); // RULE1
endmodule : adcc_conv_ctrl
`default_nettype wire

// *** verification/adcc_analog_model.sv ***
// behavioural analog front end: four channel levels and a track-and-hold
`timescale 1ns/1ps
`default_nettype none
module adcc_analog_model #(
    parameter logic [7:0] LVL0 = 8'h00,
    parameter logic [7:0] LVL1 = 8'h00,
    parameter logic [7:0] LVL2 = 8'h00,
    parameter logic [7:0] LVL3 = 8'h00
) (
    input wire logic sys_clk,
    input wire logic [1:0] channelSel,
    input wire logic trackEnable,
    input wire logic converterPowered,
    input wire logic [7:0] dacCode,
    output logic compHigh
);
    logic [7:0] lvl [4];
    logic [7:0] held;
    logic chatter = 1'b0;
    assign lvl = '{LVL0, LVL1, LVL2, LVL3};
    // mux, track, hold
    // the capacitor keeps its charge once the sample switch opens
    always @(posedge sys_clk) begin
        chatter <= ~chatter;
        if (converterPowered && trackEnable) begin
            held <= lvl[channelSel];
        end
    end
    // code steps at one lsb
    // an unpowered comparator is meaningless, so it chatters
    assign compHigh = converterPowered ? (held >= dacCode) : chatter;
endmodule : adcc_analog_model
`default_nettype wire

// *** verification/test_adc_conversion_control.sv ***
// self-checking bench for the converter control block
`timescale 1ns/1ps
`default_nettype none
`include "adcc_consts.svh"
module test_adc_conversion_control;
    localparam int OSC = 40; // one us oscillator keeps tad at 2 us or more
    localparam int RCP = 160;
    localparam logic [7:0] L0 = 8'hc5, L1 = 8'h01, L2 = 8'hff, L3 = 8'h00;
    logic sys_clk = 1'b0, rst_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
    logic [9:0] avs_address = 10'h000;
    logic [31:0] avs_writedata = 32'h0, avs_readdata;
    logic [3:0] avs_byteenable = 4'h0;
    logic avs_waitrequest, compHigh, trackEnable, converterPowered, useRefPin, wakeRequest;
    logic oscTick = 1'b0, rcClkPin = 1'b0, haltActive = 1'b0, seen = 1'b0;
    logic [1:0] channelSel;
    logic [7:0] dacCode, rdData, prevRes;
    int bad_count = 0, comparisons = 0, cycles = 0, lowCnt = 0, lastLow = 0;

    always #12.5 sys_clk = ~sys_clk;

    adcc_conv_ctrl dut (.sys_clk(sys_clk), .rst_n(rst_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .oscTick(oscTick), .rcClkPin(rcClkPin),
        .haltActive(haltActive), .compHigh(compHigh), .channelSel(channelSel),
        .trackEnable(trackEnable), .converterPowered(converterPowered),
        .useRefPin(useRefPin), .dacCode(dacCode), .wakeRequest(wakeRequest));
    adcc_analog_model #(.LVL0(L0), .LVL1(L1), .LVL2(L2), .LVL3(L3)) front (
        .sys_clk(sys_clk), .channelSel(channelSel), .trackEnable(trackEnable),
        .converterPowered(converterPowered), .dacCode(dacCode), .compHigh(compHigh));

    // clock sources, run budget and length of each non-tracking stretch
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        oscTick <= (cycles % OSC) == OSC - 1;
        rcClkPin <= (cycles % RCP) < RCP / 2;
        if (trackEnable === 1'b0) begin
            lowCnt <= lowCnt + 1;
        end else begin
            if (lowCnt != 0) lastLow <= lowCnt;
            lowCnt <= 0;
        end
        if (cycles == 80000) begin
            bad_count++;
            conclude();
        end
    end

    task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : check8

    // one bus cycle, taken at the edge where waitrequest is low, then one idle cycle
    task automatic bus(input logic wr, input logic [9:0] adr, input logic [7:0] wd);
        int n;
        n = 0;
        avs_address <= adr;
        avs_write <= wr;
        avs_read <= ~wr;
        avs_writedata <= {24'h000000, wd};
        avs_byteenable <= 4'h1;
        @(posedge sys_clk);
        while (avs_waitrequest !== 1'b0) begin
            @(posedge sys_clk);
            n++;
        end
        rdData = avs_readdata[7:0];
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        check8("wait states", 8'h01, 8'(n));
        @(posedge sys_clk);
    endtask : bus

    task automatic rd(input logic [9:0] adr, input logic [7:0] exp, input string what);
        bus(1'b0, adr, 8'h00);
        check8(what, exp, rdData);
    endtask : rd

    task automatic idle(input int n);
        repeat (n) @(posedge sys_clk);
    endtask : idle

    // full conversion with fresh tracking first; tad is in sys_clk cycles
    task automatic conv(input logic [1:0] sel, input logic [1:0] ch, input logic [7:0] exp,
                        input int tad);
        logic [7:0] base;
        int n;
        base = {sel, 1'b0, ch, 3'b001};
        n = 0;
        bus(1'b1, `ADCC_ADDR_CTRL, base);
        idle(220); // tracking time before go
        check8("tracking", 8'h01, {7'h0, trackEnable});
        check8("channel", {6'h0, ch}, {6'h0, channelSel});
        check8("trial code", 8'h80, dacCode);
        bus(1'b1, `ADCC_ADDR_CTRL, base | 8'h04);
        idle(20);
        check8("sampling stopped", 8'h00, {7'h0, trackEnable});
        if (seen) rd(`ADCC_ADDR_RES, prevRes, "result mid conversion");
        rdData = 8'h04;
        while (rdData[2] !== 1'b0 && n < 9000) begin
            bus(1'b0, `ADCC_ADDR_CTRL, 8'h00);
            n++;
        end
        check8("control after done", base | 8'h02, rdData);
        rd(`ADCC_ADDR_RES, exp, "result");
        prevRes = exp;
        seen = 1'b1;
        n = 0;
        while (trackEnable !== 1'b1 && n < 3 * tad) begin
            idle(1);
            n++;
        end
        idle(1);
        // tick phase and synchronisers allow up to one tad of slack
        check8("hold window", 8'h01,
               {7'h0, lastLow >= 11 * tad && lastLow <= 13 * tad + 10});
        bus(1'b1, `ADCC_ADDR_CTRL, base);
    endtask : conv

    task automatic conclude();
        if (bad_count == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : conclude

    // main sequence
    initial begin
        int n;
        n = 0;
        idle(20);
        rst_n <= 1'b1;
        rd(`ADCC_ADDR_CTRL, 8'h00, "control reset");
        rd(`ADCC_ADDR_PCFG, 8'h00, "pin config reset");
        rd(`ADCC_ADDR_INTC, 8'h00, "interrupt control reset");
        check8("bias at reset", 8'h00, {7'h0, converterPowered});
        bus(1'b1, 10'h030, 8'hff);
        rd(10'h030, 8'h00, "unmapped");
        bus(1'b1, `ADCC_ADDR_CTRL, 8'h24);
        rd(`ADCC_ADDR_CTRL, 8'h20, "go refused unpowered");
        check8("bias off", 8'h00, {7'h0, converterPowered});
        for (int p = 0; p < 4; p++) begin
            bus(1'b1, `ADCC_ADDR_PCFG, 8'hfc | 8'(p));
            rd(`ADCC_ADDR_PCFG, 8'(p), "pin config");
            check8("reference pin", {7'h0, 1'(p)}, {7'h0, useRefPin});
        end
        conv(2'b00, 2'h0, L0, 2 * OSC);
        conv(2'b01, 2'h1, L1, 8 * OSC);
        conv(2'b10, 2'h2, L2, 32 * OSC);
        conv(2'b11, 2'h3, L3, RCP);
        bus(1'b1, `ADCC_ADDR_RES, 8'h5a);
        rd(`ADCC_ADDR_RES, prevRes, "result read only");
        // halt in an oscillator-clocked conversion
        bus(1'b1, `ADCC_ADDR_CTRL, 8'h49);
        idle(220);
        bus(1'b1, `ADCC_ADDR_CTRL, 8'h4d);
        idle(400);
        haltActive <= 1'b1;
        idle(40);
        rd(`ADCC_ADDR_CTRL, 8'h48, "aborted control");
        check8("bias after abort", 8'h00, {7'h0, converterPowered});
        haltActive <= 1'b0;
        idle(10);
        conv(2'b01, 2'h1, L1, 8 * OSC);
        // halt in an rc-clocked conversion
        bus(1'b1, `ADCC_ADDR_INTC, 8'h40);
        rd(`ADCC_ADDR_INTC, 8'h40, "interrupt enable");
        bus(1'b1, `ADCC_ADDR_CTRL, 8'hd1);
        idle(220);
        bus(1'b1, `ADCC_ADDR_CTRL, 8'hd5);
        idle(100);
        haltActive <= 1'b1;
        while (wakeRequest !== 1'b1 && n < 3000) begin
            idle(1);
            n++;
        end
        check8("wake", 8'h01, {7'h0, wakeRequest});
        rd(`ADCC_ADDR_CTRL, 8'hd3, "control after rc halt");
        rd(`ADCC_ADDR_RES, L2, "rc halt result");
        haltActive <= 1'b0;
        conclude();
    end
endmodule : test_adc_conversion_control
`default_nettype wire
